// *** design/nst_pkg.sv ***
// Constants for the stream and transparent mode codec.
// Assumes fc-domain timing; selects come from configuration ports.
package nst_pkg;

////////////////////////////////////////////////////////////////////
// Mode encodings
localparam logic [1:0] MODE_SUBC = 2'h1;
localparam logic [1:0] MODE_BPSK = 2'h2;

////////////////////////////////////////////////////////////////////
// Timing bases in fc cycles; RST_STRETCH counts CLOCK_I cycles
localparam logic [6:0] SC_DIV_BASE = 7'h40;
localparam logic [6:0] BPSK_DIV_BASE = 7'h10;
localparam logic [1:0] BPSK_SCF_MAX = 2'h2;
localparam logic [1:0] SC_SCP_MIN = 2'h1;
localparam logic [7:0] TX_PERIOD_BASE = 8'h80;
localparam logic [3:0] SC_SILENT_LIMIT = 4'h8;
localparam logic [2:0] LAST_BIT = 3'h7;
localparam logic [3:0] RST_STRETCH = 4'h8;

////////////////////////////////////////////////////////////////////
// State types
typedef enum logic [0:0] {RX_IDLE, RX_RECV} nst_rx_state_type;
typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} nst_tx_state_type;

endpackage

// *** design/nst_codec.sv ***
// Stream and transparent mode codec between SPI pins and RF front end.
// Assumes host commands arrive as CLOCK_I pulses; fc runs on FC_CLK_I.
`timescale 1ns/1ps
module nst_codec
(
    // System clock and reset
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    // Carrier-derived link clock
    input wire logic FC_CLK_I,
    // SPI pins
    input wire logic SPI_SS_I,
    input wire logic SPI_MOSI_I,
    input wire logic SPI_SCLK_I,
    output logic SPI_MISO_O,
    output logic IRQ_O,
    // Host commands
    input wire logic CMD_TRANSPARENT_I,
    input wire logic CMD_OTHER_I,
    input wire logic CMD_TX_I,
    // Configuration
    input wire logic [1:0] MODE_I,
    input wire logic [1:0] SCF_I,
    input wire logic [1:0] SCP_I,
    input wire logic [2:0] STX_I,
    input wire logic RX_AM_EN_I,
    input wire logic RX_PM_EN_I,
    input wire logic RX_ON_CFG_I,
    input wire logic MOD_OOK_I,
    input wire logic FIELD_DETECTOR_ENABLE_I,
    input wire logic [7:0] OP_CTRL_I,
    // Front end
    input wire logic AM_SUB_I,
    input wire logic PM_SUB_I,
    input wire logic EXT_FIELD_I,
    output logic TX_MOD_O,
    output logic TX_OOK_O,
    output logic RX_ON_O,
    output logic LOW_POWER_TARGET_O,
    output logic TRANSPARENT_O,
    // FIFO side
    input wire logic [7:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    output logic TX_READY_O,
    output logic TX_BUSY_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_VALID_O,
    output logic RX_START_O,
    output logic RX_END_O
);

////////////////////////////////////////////////////////////////////
// System domain pin synchronisers
logic [5:0] pin_m_q;
logic [5:0] pin_s_q;
logic ss_d1_q;
logic ss_s, mosi_s, sclk_s, am_s, pm_s, ext_s;

always_ff @(posedge CLOCK_I)
begin
    pin_m_q <= {SPI_SS_I, SPI_MOSI_I, SPI_SCLK_I, AM_SUB_I, PM_SUB_I, EXT_FIELD_I};
    pin_s_q <= pin_m_q;
    ss_d1_q <= pin_s_q[5];
end

assign {ss_s, mosi_s, sclk_s, am_s, pm_s, ext_s} = pin_s_q;

////////////////////////////////////////////////////////////////////
// Reset stretch so the slower link domain sees a short reset
logic [3:0] rst_cnt_q;
logic rst_ext_q;

always_ff @(posedge CLOCK_I)
begin
    if (SRST_I)
        rst_cnt_q <= nst_pkg::RST_STRETCH;
    else if (rst_cnt_q != 4'h0)
        rst_cnt_q <= rst_cnt_q - 4'h1;
    rst_ext_q <= SRST_I || (rst_cnt_q != 4'h0);
end

////////////////////////////////////////////////////////////////////
// Transparent mode control
logic pend_q;
logic transp_q;
logic ss_rise;

assign ss_rise = ss_s & ~ss_d1_q;

always_ff @(posedge CLOCK_I)
begin
    if (SRST_I)
    begin
        pend_q <= 1'b0;
        transp_q <= 1'b0;
    end
    else if (CMD_TRANSPARENT_I)
    begin
        pend_q <= 1'b1;
        transp_q <= 1'b0;
    end
    else if (CMD_OTHER_I)
    begin
        pend_q <= 1'b0;
        transp_q <= 1'b0;
    end
    else if (ss_rise && pend_q)
    begin
        pend_q <= 1'b0;
        transp_q <= 1'b1;
    end
    else if (!ss_s)
    begin
        transp_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////
// Pin outputs
logic mod_s;
logic single_ch;

assign single_ch = RX_AM_EN_I ^ RX_PM_EN_I;

always_ff @(posedge CLOCK_I)
begin
    if (SRST_I)
    begin
        TX_MOD_O <= 1'b0;
        RX_ON_O <= 1'b0;
        SPI_MISO_O <= 1'b0;
        IRQ_O <= 1'b0;
        TX_OOK_O <= 1'b0;
        LOW_POWER_TARGET_O <= 1'b0;
        TRANSPARENT_O <= 1'b0;
    end
    else
    begin
        TX_MOD_O <= transp_q ? mosi_s : (mod_s & ~rst_ext_q);
        RX_ON_O <= transp_q ? sclk_s : RX_ON_CFG_I;
        TX_OOK_O <= MOD_OOK_I;
        TRANSPARENT_O <= transp_q;
        LOW_POWER_TARGET_O <= FIELD_DETECTOR_ENABLE_I && (OP_CTRL_I == 8'h00);
        if (!transp_q)
            SPI_MISO_O <= 1'b0;
        else if (single_ch)
            SPI_MISO_O <= RX_AM_EN_I ? am_s : pm_s;
        else
            SPI_MISO_O <= am_s;
        if (!transp_q)
            IRQ_O <= 1'b0;
        else if (FIELD_DETECTOR_ENABLE_I)
            IRQ_O <= ext_s;
        else if (single_ch)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= pm_s;
    end
end

sequence ss_rise_armed_s;
    ss_rise && pend_q && !CMD_TRANSPARENT_I && !CMD_OTHER_I;
endsequence

transp_enter_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    ss_rise_armed_s |=> transp_q ##1 TRANSPARENT_O)
    else $error("transparent mode not entered");
transp_exit_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    CMD_OTHER_I |=> !transp_q ##1 !TRANSPARENT_O)
    else $error("command did not end transparent mode");
mosi_mod_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    transp_q |=> TX_MOD_O == $past(mosi_s))
    else $error("modulator not following data-in");
sclk_rxon_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    transp_q |=> RX_ON_O == $past(sclk_s))
    else $error("receiver activate not following clock pin");
single_irq_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    transp_q && single_ch && !FIELD_DETECTOR_ENABLE_I |=> !IRQ_O)
    else $error("interrupt pin not low with single channel");
fd_irq_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    transp_q && FIELD_DETECTOR_ENABLE_I |=> IRQ_O == $past(ext_s))
    else $error("field detector not on interrupt pin");

////////////////////////////////////////////////////////////////////
// Transmit byte handshake and start toggle
logic [7:0] tx_buf_q;
logic tx_req_q;
logic start_tgl_q;
logic [4:0] back_m_q;
logic [4:0] back_s_q;
logic [2:0] back_d_q;
logic busy_m_q;
logic busy_s_q;
logic tx_ack_f_q;
logic rx_tgl_f_q;
logic sof_tgl_f_q;
logic eof_tgl_f_q;
logic mod_f_q;
logic txact_f_q;
logic [7:0] rx_byte_f_q;
logic take;
logic ack_s;

assign ack_s = back_s_q[4];
assign mod_s = back_s_q[3];
assign take = TX_VALID_I & TX_READY_O;

always_ff @(posedge CLOCK_I)
begin
    back_m_q <= {tx_ack_f_q, mod_f_q, rx_tgl_f_q, sof_tgl_f_q, eof_tgl_f_q};
    back_s_q <= back_m_q;
    back_d_q <= back_s_q[2:0];
    busy_m_q <= txact_f_q;
    busy_s_q <= busy_m_q;
end

always_ff @(posedge CLOCK_I)
begin
    if (SRST_I || rst_ext_q)
    begin
        tx_buf_q <= 8'h00;
        tx_req_q <= 1'b0;
        start_tgl_q <= 1'b0;
        TX_READY_O <= 1'b0;
    end
    else
    begin
        if (take)
        begin
            tx_buf_q <= TX_DATA_I;
            tx_req_q <= ~tx_req_q;
        end
        if (CMD_TX_I && !transp_q)
            start_tgl_q <= ~start_tgl_q;
        TX_READY_O <= (tx_req_q == ack_s) && !take && !transp_q;
    end
end

////////////////////////////////////////////////////////////////////
// Receive results back into system domain
always_ff @(posedge CLOCK_I)
begin
    if (SRST_I || rst_ext_q)
    begin
        RX_DATA_O <= 8'h00;
        RX_VALID_O <= 1'b0;
        RX_START_O <= 1'b0;
        RX_END_O <= 1'b0;
        TX_BUSY_O <= 1'b0;
    end
    else
    begin
        RX_VALID_O <= back_s_q[2] ^ back_d_q[2];
        RX_START_O <= back_s_q[1] ^ back_d_q[1];
        RX_END_O <= back_s_q[0] ^ back_d_q[0];
        TX_BUSY_O <= busy_s_q;
        if (back_s_q[2] ^ back_d_q[2])
            RX_DATA_O <= rx_byte_f_q;
    end
end

////////////////////////////////////////////////////////////////////
// Link domain reset and input synchronisers
logic rst_m_q;
logic rst_f_q;
logic [14:0] cfg_m_q;
logic [14:0] cfg_s_q;
logic am_d_q;
logic start_d_q;
logic transp_f;
logic [1:0] mode_f;
logic [1:0] scf_f;
logic [1:0] scp_f;
logic [2:0] stx_f;
logic start_f;
logic req_f;
logic am_f;

always_ff @(posedge FC_CLK_I)
begin
    rst_m_q <= rst_ext_q;
    rst_f_q <= rst_m_q;
    cfg_m_q <= {transp_q, MODE_I, SCF_I, SCP_I, STX_I, start_tgl_q, tx_req_q, AM_SUB_I, 2'h0};
    cfg_s_q <= cfg_m_q;
    am_d_q <= am_f;
    start_d_q <= start_f;
end

assign {transp_f, mode_f, scf_f, scp_f, stx_f, start_f, req_f, am_f} = cfg_s_q[14:2];

////////////////////////////////////////////////////////////////////
// Reporting period timing
logic is_sc;
logic stream_en;
logic [6:0] div;
logic [1:0] scp_eff;
logic [9:0] period_len;
logic [9:0] per_cnt_q;
logic per_end;
logic seen_q;
logic phase_q;
logic det;

assign is_sc = (mode_f == nst_pkg::MODE_SUBC);
assign stream_en = (is_sc || mode_f == nst_pkg::MODE_BPSK) && !transp_f;
assign div = is_sc ? (nst_pkg::SC_DIV_BASE >> scf_f)
    : (nst_pkg::BPSK_DIV_BASE >> ((scf_f > nst_pkg::BPSK_SCF_MAX) ?
        nst_pkg::BPSK_SCF_MAX : scf_f));
assign scp_eff = (is_sc && scp_f < nst_pkg::SC_SCP_MIN) ? nst_pkg::SC_SCP_MIN : scp_f;
assign period_len = {3'h0, div} << scp_eff;
assign per_end = (per_cnt_q >= period_len - 10'h001);
assign det = seen_q | (am_f & ~am_d_q);

always_ff @(posedge FC_CLK_I)
begin
    if (rst_f_q || !stream_en || per_end)
        per_cnt_q <= 10'h000;
    else
        per_cnt_q <= per_cnt_q + 10'h001;
end

always_ff @(posedge FC_CLK_I)
begin
    if (rst_f_q || per_end)
        seen_q <= 1'b0;
    else
        seen_q <= det;
    if (rst_f_q)
        phase_q <= 1'b0;
    else if (per_cnt_q == {5'h00, div[6:2]})
        phase_q <= am_f;
end

////////////////////////////////////////////////////////////////////
// Receive decoder
nst_pkg::nst_rx_state_type rx_state_q;
nst_pkg::nst_tx_state_type tx_state_q;
logic ref_q;
logic [3:0] silent_q;
logic [2:0] rx_bit_q;
logic [7:0] rx_acc_q;
logic rx_push;
logic rx_val;
logic rx_stop;
logic rx_en;

assign rx_en = stream_en && (tx_state_q == nst_pkg::TX_IDLE);

always_comb
begin
    rx_push = 1'b0;
    rx_val = 1'b0;
    rx_stop = 1'b0;
    if (per_end && rx_en)
    begin
        unique case (rx_state_q)
            nst_pkg::RX_IDLE:
            begin
                rx_push = det;
                rx_val = is_sc;
            end
            nst_pkg::RX_RECV:
            begin
                if (is_sc)
                begin
                    rx_stop = !det && (silent_q == nst_pkg::SC_SILENT_LIMIT);
                    rx_push = !rx_stop;
                    rx_val = det;
                end
                else
                begin
                    rx_stop = !det;
                    rx_push = det;
                    rx_val = phase_q ^ ref_q;
                end
            end
        endcase
    end
end

always_ff @(posedge FC_CLK_I)
begin
    if (rst_f_q || !rx_en)
    begin
        rx_state_q <= nst_pkg::RX_IDLE;
        silent_q <= 4'h0;
        ref_q <= 1'b0;
    end
    else if (per_end)
    begin
        if (rx_state_q == nst_pkg::RX_IDLE && det)
        begin
            rx_state_q <= nst_pkg::RX_RECV;
            ref_q <= phase_q;
            silent_q <= 4'h0;
        end
        else if (rx_stop)
            rx_state_q <= nst_pkg::RX_IDLE;
        else if (rx_state_q == nst_pkg::RX_RECV)
            silent_q <= det ? 4'h0 : silent_q + 4'h1;
    end
end

always_ff @(posedge FC_CLK_I)
begin
    if (rst_f_q)
    begin
        rx_bit_q <= 3'h0;
        rx_acc_q <= 8'h00;
        rx_byte_f_q <= 8'h00;
        rx_tgl_f_q <= 1'b0;
        sof_tgl_f_q <= 1'b0;
        eof_tgl_f_q <= 1'b0;
    end
    else
    begin
        if (rx_push && rx_state_q == nst_pkg::RX_IDLE)
            sof_tgl_f_q <= ~sof_tgl_f_q;
        if (rx_push && rx_bit_q == nst_pkg::LAST_BIT)
        begin
            rx_byte_f_q <= rx_acc_q | ({7'h00, rx_val} << rx_bit_q);
            rx_tgl_f_q <= ~rx_tgl_f_q;
            rx_acc_q <= 8'h00;
            rx_bit_q <= 3'h0;
        end
        else if (rx_push)
        begin
            rx_acc_q <= rx_acc_q | ({7'h00, rx_val} << rx_bit_q);
            rx_bit_q <= rx_bit_q + 3'h1;
        end
        else if (rx_stop)
        begin
            eof_tgl_f_q <= ~eof_tgl_f_q;
            rx_acc_q <= 8'h00;
            rx_bit_q <= 3'h0;
            if (rx_bit_q != 3'h0)
            begin
                rx_byte_f_q <= rx_acc_q;
                rx_tgl_f_q <= ~rx_tgl_f_q;
            end
        end
    end
end

bpsk_end_a: assert property (@(posedge FC_CLK_I) disable iff (rst_f_q)
    rx_en && !is_sc && rx_state_q == nst_pkg::RX_RECV && per_end && !det
    |=> rx_state_q == nst_pkg::RX_IDLE && eof_tgl_f_q != $past(eof_tgl_f_q))
    else $error("BPSK receive not ended on silent period");
sc_silence_a: assert property (@(posedge FC_CLK_I) disable iff (rst_f_q)
    rx_state_q == nst_pkg::RX_RECV && is_sc |-> silent_q <= nst_pkg::SC_SILENT_LIMIT)
    else $error("subcarrier silence count beyond limit");
sc_period_a: assert property (@(posedge FC_CLK_I) disable iff (rst_f_q)
    stream_en && is_sc && scf_f == 2'h1 && scp_f == 2'h2 |-> period_len == 10'h080)
    else $error("subcarrier period wrong for 01b/10b");

////////////////////////////////////////////////////////////////////
// Transmit serialiser
logic [7:0] tx_sh_q;
logic [2:0] tx_bit_q;
logic [7:0] tx_cnt_q;
logic [7:0] tx_len;
logic tx_pend;

assign tx_len = nst_pkg::TX_PERIOD_BASE >> stx_f;
assign tx_pend = (req_f != tx_ack_f_q);

always_ff @(posedge FC_CLK_I)
begin
    if (rst_f_q || !stream_en)
    begin
        tx_state_q <= nst_pkg::TX_IDLE;
        tx_sh_q <= 8'h00;
        tx_bit_q <= 3'h0;
        tx_cnt_q <= 8'h00;
        tx_ack_f_q <= req_f;
        mod_f_q <= 1'b0;
    end
    else
    begin
        unique case (tx_state_q)
            nst_pkg::TX_IDLE:
                if (start_f != start_d_q)
                    tx_state_q <= nst_pkg::TX_LOAD;
            nst_pkg::TX_LOAD:
            begin
                mod_f_q <= 1'b0;
                if (tx_pend)
                begin
                    tx_sh_q <= tx_buf_q;
                    tx_ack_f_q <= req_f;
                    tx_bit_q <= 3'h0;
                    tx_cnt_q <= 8'h00;
                    tx_state_q <= nst_pkg::TX_SEND;
                end
                else
                    tx_state_q <= nst_pkg::TX_IDLE;
            end
            nst_pkg::TX_SEND:
            begin
                mod_f_q <= tx_sh_q[tx_bit_q];
                if (tx_cnt_q == tx_len - 8'h01)
                begin
                    tx_cnt_q <= 8'h00;
                    tx_bit_q <= tx_bit_q + 3'h1;
                    if (tx_bit_q == nst_pkg::LAST_BIT)
                        tx_state_q <= nst_pkg::TX_LOAD;
                end
                else
                    tx_cnt_q <= tx_cnt_q + 8'h01;
            end
            default:
                tx_state_q <= nst_pkg::TX_IDLE;
        endcase
    end
end

always_ff @(posedge FC_CLK_I)
begin
    if (rst_f_q)
        txact_f_q <= 1'b0;
    else
        txact_f_q <= (tx_state_q != nst_pkg::TX_IDLE);
end

tx_bit_period_a: assert property (@(posedge FC_CLK_I) disable iff (rst_f_q)
    tx_state_q == nst_pkg::TX_SEND && stx_f == 3'h0 |-> tx_len == 8'h80 && tx_cnt_q < tx_len)
    else $error("Tx bit period not 128 fc cycles");

endmodule

// *** tb/nst_fe_model.sv ***
// Front end model: demodulated subcarrier and field detector levels.
// Assumes the bench supplies the fc clock; levels change at fc edges.
`timescale 1ns/1ps
module nst_fe_model
(
    // Link clock
    input wire logic fc_clk_i,
    // Demodulated outputs
    output logic am_o,
    output logic pm_o,
    output logic ext_o
);
    initial
    begin
        am_o = 1'b0;
        pm_o = 1'b0;
        ext_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Static levels
    task automatic set_lv(input logic a, input logic p, input logic e);
        @(posedge fc_clk_i);
        am_o <= a;
        pm_o <= p;
        ext_o <= e;
    endtask

    ////////////////////////////////////////////////////////////////
    // Burst of n periods, phase inverted from period flip on
    task automatic burst(input int dv, input int pl, input int n, input int flip);
        for (int p = 0; p < n; p++)
        begin
            for (int c = 0; c < pl; c++)
            begin
                @(posedge fc_clk_i);
                am_o <= ((c % dv) < dv / 2) ^ (p >= flip);
            end
        end
        @(posedge fc_clk_i);
        am_o <= 1'b0;
    endtask
endmodule

// *** tb/nst_codec_tb_top.sv ***
// Self-checking bench for the stream and transparent mode codec.
// Assumes a 40 ns system clock and an unrelated 80 ns fc clock.
`timescale 1ns/1ps
module nst_codec_tb_top;
    logic clk = 1'b0;
    logic fc = 1'b0;
    logic rst = 1'b1;
    logic ss, mosi, sclk, c_tr, c_ot, c_tx, am_en, pm_en, rxcfg, ook, fde, tvalid;
    logic [1:0] mode, scf, scp;
    logic [2:0] stx;
    logic [7:0] opc, tdata, rdata, last_rx, first_rx, r, b;
    logic miso, irq, txmod, txook, rxon, lpt, transp, tready, tbusy, rvalid, rstart, rend;
    logic am, pm, ext;
    logic [15:0] lfsr_q = 16'h3BE3;
    int errors = 0;
    int samples_checked = 0;
    int starts = 0;
    int ends = 0;
    int end_t = 0;
    int cyc = 0;
    int rxn = 0;

    always #20 clk = ~clk;
    initial
    begin
        #13;
        forever #40 fc = ~fc;
    end

    nst_codec DUT
    (
        .CLOCK_I(clk), .SRST_I(rst), .FC_CLK_I(fc),
        .SPI_SS_I(ss), .SPI_MOSI_I(mosi), .SPI_SCLK_I(sclk),
        .SPI_MISO_O(miso), .IRQ_O(irq),
        .CMD_TRANSPARENT_I(c_tr), .CMD_OTHER_I(c_ot), .CMD_TX_I(c_tx),
        .MODE_I(mode), .SCF_I(scf), .SCP_I(scp), .STX_I(stx),
        .RX_AM_EN_I(am_en), .RX_PM_EN_I(pm_en), .RX_ON_CFG_I(rxcfg),
        .MOD_OOK_I(ook), .FIELD_DETECTOR_ENABLE_I(fde), .OP_CTRL_I(opc),
        .AM_SUB_I(am), .PM_SUB_I(pm), .EXT_FIELD_I(ext),
        .TX_MOD_O(txmod), .TX_OOK_O(txook), .RX_ON_O(rxon),
        .LOW_POWER_TARGET_O(lpt), .TRANSPARENT_O(transp),
        .TX_DATA_I(tdata), .TX_VALID_I(tvalid), .TX_READY_O(tready),
        .TX_BUSY_O(tbusy), .RX_DATA_O(rdata), .RX_VALID_O(rvalid),
        .RX_START_O(rstart), .RX_END_O(rend)
    );

    nst_fe_model fe
    (
        .fc_clk_i(fc), .am_o(am), .pm_o(pm), .ext_o(ext)
    );

    ////////////////////////////////////////////////////////////////
    // Receive monitor
    always @(posedge clk)
    begin
        cyc++;
        if (rvalid === 1'b1)
        begin
            if (rxn == 0)
                first_rx = rdata;
            last_rx = rdata;
            rxn++;
        end
        if (rstart === 1'b1)
            starts++;
        if (rend === 1'b1)
        begin
            ends++;
            end_t = cyc;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd(output logic [7:0] v);
        lfsr_q = lfsr_next(lfsr_q);
        v = lfsr_q[7:0];
    endtask

    function automatic int sdiv(input logic bp, input logic [1:0] f);
        return bp ? (16 >> f) : (64 >> f);
    endfunction

    function automatic int plen(input logic bp, input logic [1:0] f, input logic [1:0] q);
        return sdiv(bp, f) * ((!bp && q == 2'h0) ? 2 : (1 << q));
    endfunction

    function automatic logic cond(input int k, input int e0);
        case (k)
            0: return tready === 1'b1;
            1: return tbusy === 1'b0;
            default: return ends > e0;
        endcase
    endfunction

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi);
        samples_checked++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask

    task automatic wait_for(input int k, input int e0, input int lim);
        int i;
        i = 0;
        while (!cond(k, e0) && i < lim)
        begin
            @(posedge clk);
            i++;
        end
        if (i >= lim)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
            give_verdict();
        end
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: c_tr <= 1'b1;
            1: c_ot <= 1'b1;
            default: c_tx <= 1'b1;
        endcase
        @(posedge clk);
        {c_tr, c_ot, c_tx} <= 3'b000;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int s0, e0, p, k, n, pl, el;
        logic bp;
        {ss, mosi, sclk, c_tr, c_ot, c_tx, am_en, pm_en, rxcfg, ook, fde, tvalid} = '0;
        {mode, scf, scp, stx, opc, tdata} = '0;
        repeat (2) @(posedge clk);
        chk({miso, irq, txmod, lpt, transp, tbusy, tready, rvalid, rstart, rend}, 16'h0000);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        // Transparent mode
        mode <= 2'h1;
        s0 = starts;
        pulse(0);
        @(posedge clk);
        ss <= 1'b1;
        repeat (8) @(posedge clk);
        chk(transp, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            rnd(r);
            rnd(b);
            mosi <= r[0];
            sclk <= r[1];
            am_en <= r[2] | ~r[3];
            pm_en <= r[3];
            fde <= r[4];
            opc <= r[5] ? 8'h00 : b;
            fe.set_lv(b[0], b[1], b[2]);
            repeat (8) @(posedge clk);
            chk(txmod, r[0]);
            chk(rxon, r[1]);
            chk(miso, (r[2] | ~r[3]) ? b[0] : b[1]);
            chk(irq, r[4] ? b[2] : ((r[2] & r[3]) ? b[1] : 1'b0));
            chk(lpt, r[4] && (r[5] || b == 8'h00));
        end
        pulse(2);
        repeat (6) @(posedge clk);
        chk(transp, 1'b1);
        chk(starts - s0, 0);
        chk({tready, tbusy}, 16'h0000);
        rxcfg <= 1'b1;
        pulse(1);
        repeat (4) @(posedge clk);
        chk(transp, 1'b0);
        chk(rxon, 1'b1);
        ss <= 1'b0;
        repeat (6) @(posedge clk);
        ss <= 1'b1;
        repeat (8) @(posedge clk);
        chk(transp, 1'b0);
        ss <= 1'b0;
        pulse(0);
        ss <= 1'b1;
        repeat (8) @(posedge clk);
        chk(transp, 1'b1);
        ss <= 1'b0;
        repeat (8) @(posedge clk);
        chk(transp, 1'b0);
        $display("Test transparent done");
        // Transmit stream
        for (int i = 0; i < 3; i++)
        begin
            rnd(r);
            stx <= (i == 0) ? 3'h0 : 3'(1 + r % 3);
            p = 128 >> ((i == 0) ? 0 : (1 + r % 3));
            ook <= r[3];
            repeat (6) @(posedge clk);
            wait_for(0, 0, 200);
            rnd(b);
            b = b | 8'h01;
            @(posedge clk);
            tdata <= b;
            tvalid <= 1'b1;
            @(posedge clk);
            tvalid <= 1'b0;
            pulse(2);
            k = 0;
            while (txmod !== 1'b1 && k < 400)
            begin
                @(posedge fc);
                k++;
            end
            chk_rng(k, 0, 399);
            for (int j = 0; j < 8; j++)
            begin
                repeat ((j == 0) ? p / 2 : p) @(posedge fc);
                chk(txmod, b[j]);
            end
            chk(tbusy, 1'b1);
            chk(txook, r[3]);
            wait_for(1, 0, 4 * p);
            chk(txmod, 1'b0);
        end
        $display("Test transmit done");
        // Receive stream, subcarrier then BPSK
        for (int i = 0; i < 6; i++)
        begin
            rnd(r);
            bp = (i >= 3);
            scf <= (i == 0) ? 2'h1 : (bp ? 2'(r % 3) : r[1:0]);
            scp <= (i == 0) ? 2'h2 : r[3:2];
            mode <= bp ? 2'h2 : 2'h1;
            pl = plen(bp, (i == 0) ? 2'h1 : (bp ? 2'(r % 3) : r[1:0]), (i == 0) ? 2'h2 : r[3:2]);
            n = bp ? 6 : 1 + r[6:4] % 6;
            repeat (10) @(posedge clk);
            s0 = starts;
            e0 = ends;
            rxn = 0;
            fe.burst(sdiv(bp, (i == 0) ? 2'h1 : (bp ? 2'(r % 3) : r[1:0])), pl, n, bp ? 3 : n);
            k = cyc;
            wait_for(2, e0, 24 * pl + 100);
            el = end_t - k;
            chk(starts - s0, 1);
            if (!bp)
            begin
                chk(first_rx == (8'hFF >> (8 - n)) || first_rx == (8'hFF >> (7 - n)), 1);
                chk(last_rx, 8'h00);
                chk(rxn, 2);
                chk_rng(el, 16 * pl, 20 * pl + 20);
            end
            else
            begin
                chk(last_rx[0], 1'b0);
                chk(last_rx != 8'h00, 1'b1);
                chk(rxn, 1);
                chk_rng(el, 0, 4 * pl + 20);
            end
        end
        $display("Test receive done");
        give_verdict();
    end
endmodule
